// file: fcr_defs.vh
// Constants for the frequency correction and transmit rate block.
// Assumes inclusion by bare name from the design files of this block.
// Function
// - Deviation equals code times 625 Hz step
// - Deviation code top bit 71h, low 72h
// - Manual offset code signed, scaled by band
// - Manual offset except correction enabled in receive
// - Correction retunes synthesizer by measured offset
// - Correction frozen from preamble to packet end
// - Multi-packet: correction cleared after each packet
// - Correction limited to limiter times band times 625
// - Gear field halves feedback per step
// - Measure two bits, apply, then settle
// - Wait field sets settle; zero suppresses output
// - Correction value readable at 2Bh
// - Rate is code times 1 MHz over 2^(16+5s)
// - Transmit rate code used only in transmit
// - Band select doubles offset, limiter, correction step
`ifndef FCR_DEFS_VH
`define FCR_DEFS_VH

// ==================================================================
// Register addresses
`define FCR_ADDR_LIMIT      7'h2a
`define FCR_ADDR_CORR       7'h2b
`define FCR_ADDR_RATE_HI    7'h6e
`define FCR_ADDR_RATE_LO    7'h6f
`define FCR_ADDR_RATE_CFG   7'h70
`define FCR_ADDR_MOD_CTRL2  7'h71
`define FCR_ADDR_DEV_LO     7'h72
`define FCR_ADDR_OFS_LO     7'h73
`define FCR_ADDR_OFS_HI     7'h74
`define FCR_ADDR_BAND       7'h75

// ==================================================================
// Reset values
`define FCR_RST_LIMIT       8'h00
`define FCR_RST_RATE_HI     8'h0a
`define FCR_RST_RATE_LO     8'h3d
`define FCR_RST_RATE_CFG    8'h00
`define FCR_RST_MOD_CTRL2   8'h00
`define FCR_RST_DEV_LO      8'h20
`define FCR_RST_OFS_LO      8'h00
`define FCR_RST_OFS_HI      8'h00
`define FCR_RST_BAND        8'h35

// ==================================================================
// Field positions
`define FCR_DEV_TOP_BIT     2
`define FCR_BAND_HI_BIT     5
`define FCR_RATE_SCALE_BIT  5
`define FCR_OFS_HI_MASK     8'h03

// ==================================================================
// Timing and arithmetic
`define FCR_CLK_HZ          40000000
`define FCR_REF_HZ          1000000
`define FCR_REF_DIV         (`FCR_CLK_HZ / `FCR_REF_HZ)
`define FCR_RATE_SHIFT_LO   16
`define FCR_RATE_SHIFT_HI   21
`define FCR_MEAS_BITS       4'h2
`define FCR_LIMIT_SHIFT     2

`endif

// file: fcr_rate_gen.v
// Transmit bit-rate generator: phase accumulator paced by a 1 MHz tick.
// Assumes the rate code and scale bit come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "fcr_defs.vh"

module fcr_rate_gen #(
    parameter integer REF_DIV = `FCR_REF_DIV
) (
    // Clock and reset
    input  wire        mclk_in,
    input  wire        sys_rst_in,
    // Control
    input  wire        enable_in,
    input  wire [15:0] rate_code_in,
    input  wire        rate_scale_in,
    // Bit pulse
    output reg         bit_tick_out
);
    // ==============================================================
    // 1 MHz reference enable
    reg  [7:0]  ref_cnt_q;
    wire        ref_tick = ({24'h000000, ref_cnt_q} == REF_DIV - 1);

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ref_cnt_q <= 8'h00;
        end else if (ref_tick || !enable_in) begin
            ref_cnt_q <= 8'h00;
        end else begin
            ref_cnt_q <= ref_cnt_q + 8'h01;
        end
    end

    // ==============================================================
    // Accumulator: carry out of bit 16 or 21 marks one bit time
    reg  [21:0] acc_q;
    wire [22:0] acc_sum = {1'b0, acc_q} + {7'h00, rate_code_in};
    wire        carry   = rate_scale_in ? acc_sum[`FCR_RATE_SHIFT_HI]
                                        : acc_sum[`FCR_RATE_SHIFT_LO];

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            acc_q        <= 22'h000000;
            bit_tick_out <= 1'b0;
        end else if (!enable_in) begin
            acc_q        <= 22'h000000;
            bit_tick_out <= 1'b0;
        end else begin
            bit_tick_out <= ref_tick && carry;
            if (ref_tick) begin
                if (rate_scale_in) begin
                    acc_q <= {1'b0, acc_sum[20:0]};
                end else begin
                    acc_q <= {6'h00, acc_sum[15:0]};
                end
            end
        end
    end
endmodule // fcr_rate_gen
`default_nettype wire

// file: fcr_top.v
// Frequency deviation, manual offset, correction loop and transmit rate.
// Assumes a host-side serial engine turns transfers into the byte-wide
// register strobes below, and the modem supplies bit ticks and errors.
`timescale 1ns/1ps
`default_nettype none
`include "fcr_defs.vh"

module fcr_top (
    // Clock and reset
    input  wire        mclk_in,
    input  wire        sys_rst_in,
    // Register access
    input  wire [6:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_we_in,
    input  wire        reg_re_in,
    output reg  [7:0]  reg_rdata_out,
    // Mode and loop settings
    input  wire        rx_mode_in,
    input  wire        tx_mode_in,
    input  wire        afc_enable_in,
    input  wire [2:0]  afc_gear_in,
    input  wire [2:0]  settle_wait_in,
    input  wire        multi_packet_in,
    // Modem events
    input  wire        rx_bit_tick_in,
    input  wire signed [10:0] freq_err_in,
    input  wire        preamble_det_in,
    input  wire        packet_end_in,
    // Synthesizer settings
    output reg  [8:0]  deviation_code_out,
    output reg  [9:0]  lo_offset_out,
    output reg         high_band_out,
    output reg         afc_frozen_out,
    output reg         tx_bit_tick_out
);
    // ==============================================================
    // Helpers
    function [9:0] clamp10;
        input signed [12:0] v;
        input [9:0]         lim;
        reg signed [12:0]   l;
        reg signed [12:0]   nl;
        begin
            l = {3'b000, lim};
            // A wide limiter would overflow the signed 10-bit correction
            if (l > 13'sd511) begin
                l = 13'sd511;
            end
            nl = -l;
            if (v > l) begin
                clamp10 = l[9:0];
            end else if (v < nl) begin
                clamp10 = nl[9:0];
            end else begin
                clamp10 = v[9:0];
            end
        end
    endfunction

    function [7:0] sat8;
        input signed [9:0] v;
        begin
            if (v > 10'sd127) begin
                sat8 = 8'h7f;
            end else if (v < -10'sd128) begin
                sat8 = 8'h80;
            end else begin
                sat8 = v[7:0];
            end
        end
    endfunction

    // ==============================================================
    // Register file
    reg  [7:0] limit_q;
    reg  [7:0] rate_hi_q;
    reg  [7:0] rate_lo_q;
    reg  [7:0] rate_cfg_q;
    reg  [7:0] mod_ctrl2_q;
    reg  [7:0] dev_lo_q;
    reg  [7:0] ofs_lo_q;
    reg  [7:0] ofs_hi_q;
    reg  [7:0] band_q;
    reg  [9:0] corr_q;

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            limit_q     <= `FCR_RST_LIMIT;
            rate_hi_q   <= `FCR_RST_RATE_HI;
            rate_lo_q   <= `FCR_RST_RATE_LO;
            rate_cfg_q  <= `FCR_RST_RATE_CFG;
            mod_ctrl2_q <= `FCR_RST_MOD_CTRL2;
            dev_lo_q    <= `FCR_RST_DEV_LO;
            ofs_lo_q    <= `FCR_RST_OFS_LO;
            ofs_hi_q    <= `FCR_RST_OFS_HI;
            band_q      <= `FCR_RST_BAND;
        end else if (reg_we_in) begin
            case (reg_addr_in)
                `FCR_ADDR_LIMIT:     limit_q     <= reg_wdata_in;
                `FCR_ADDR_RATE_HI:   rate_hi_q   <= reg_wdata_in;
                `FCR_ADDR_RATE_LO:   rate_lo_q   <= reg_wdata_in;
                `FCR_ADDR_RATE_CFG:  rate_cfg_q  <= reg_wdata_in;
                `FCR_ADDR_MOD_CTRL2: mod_ctrl2_q <= reg_wdata_in;
                `FCR_ADDR_DEV_LO:    dev_lo_q    <= reg_wdata_in;
                `FCR_ADDR_OFS_LO:    ofs_lo_q    <= reg_wdata_in;
                `FCR_ADDR_OFS_HI:    ofs_hi_q    <= reg_wdata_in & `FCR_OFS_HI_MASK;
                `FCR_ADDR_BAND:      band_q      <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // Reads are registered; unmapped addresses return zero
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_re_in) begin
            case (reg_addr_in)
                `FCR_ADDR_LIMIT:     reg_rdata_out <= limit_q;
                `FCR_ADDR_CORR:      reg_rdata_out <= sat8(corr_q);
                `FCR_ADDR_RATE_HI:   reg_rdata_out <= rate_hi_q;
                `FCR_ADDR_RATE_LO:   reg_rdata_out <= rate_lo_q;
                `FCR_ADDR_RATE_CFG:  reg_rdata_out <= rate_cfg_q;
                `FCR_ADDR_MOD_CTRL2: reg_rdata_out <= mod_ctrl2_q;
                `FCR_ADDR_DEV_LO:    reg_rdata_out <= dev_lo_q;
                `FCR_ADDR_OFS_LO:    reg_rdata_out <= ofs_lo_q;
                `FCR_ADDR_OFS_HI:    reg_rdata_out <= ofs_hi_q;
                `FCR_ADDR_BAND:      reg_rdata_out <= band_q;
                default:             reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // ==============================================================
    // Correction loop
    localparam [1:0] ST_IDLE   = 2'b00;
    localparam [1:0] ST_MEAS   = 2'b01;
    localparam [1:0] ST_SETTLE = 2'b10;
    localparam [1:0] ST_FROZEN = 2'b11;

    reg  [1:0]         state_q;
    reg  [3:0]         bit_cnt_q;
    reg  signed [11:0] err_sum_q;

    wire        loop_on   = rx_mode_in && afc_enable_in;
    // Limiter counts 625 Hz steps, correction counts 156.25 Hz steps; band
    // scales both alike, so the bound in correction steps is limiter x 4.
    wire [9:0]  lim_steps = {limit_q, 2'b00};
    wire [3:0]  settle_bits = {settle_wait_in, 1'b0};
    wire signed [11:0] err_next = err_sum_q + {freq_err_in[10], freq_err_in};
    // Average of the two samples, then the gear shift halves it per step
    wire signed [12:0] fb_step  =
        $signed({{2{err_next[11]}}, err_next[11:1]}) >>> afc_gear_in;
    wire signed [12:0] corr_new = {{3{corr_q[9]}}, corr_q} + fb_step;

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            err_sum_q <= 12'sh000;
            corr_q    <= 10'h000;
        end else if (!loop_on) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            err_sum_q <= 12'sh000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_q   <= ST_MEAS;
                    bit_cnt_q <= 4'h0;
                    err_sum_q <= 12'sh000;
                end
                ST_MEAS: begin
                    if (preamble_det_in) begin
                        state_q <= ST_FROZEN;
                    end else if (rx_bit_tick_in) begin
                        err_sum_q <= err_next;
                        if (bit_cnt_q == `FCR_MEAS_BITS - 4'h1) begin
                            bit_cnt_q <= 4'h0;
                            state_q   <= ST_SETTLE;
                            if (settle_wait_in == 3'b000) begin
                                corr_q <= 10'h000;
                            end else begin
                                corr_q <= clamp10(corr_new, lim_steps);
                            end
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                ST_SETTLE: begin
                    if (preamble_det_in) begin
                        state_q <= ST_FROZEN;
                    end else if (bit_cnt_q >= settle_bits) begin
                        state_q   <= ST_MEAS;
                        bit_cnt_q <= 4'h0;
                        err_sum_q <= 12'sh000;
                    end else if (rx_bit_tick_in) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                end
                ST_FROZEN: begin
                    if (packet_end_in) begin
                        state_q <= ST_IDLE;
                        if (multi_packet_in) begin
                            corr_q <= 10'h000;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            // Zero wait clears the correction every cycle while the loop is on
            if (settle_wait_in == 3'b000) begin
                corr_q <= 10'h000;
            end
        end
    end

    // ==============================================================
    // Synthesizer settings
    wire [9:0] manual_offset_code = {ofs_hi_q[1:0], ofs_lo_q};

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            deviation_code_out <= 9'h000;
            lo_offset_out      <= 10'h000;
            high_band_out      <= 1'b0;
            afc_frozen_out     <= 1'b0;
        end else begin
            // Same 625 Hz step in both bands; carrier fields do not enter
            deviation_code_out <= {mod_ctrl2_q[`FCR_DEV_TOP_BIT], dev_lo_q};
            high_band_out      <= band_q[`FCR_BAND_HI_BIT];
            afc_frozen_out     <= loop_on && (state_q == ST_FROZEN);
            // Loop and manual code share one offset path
            if (loop_on && !tx_mode_in) begin
                lo_offset_out <= corr_q;
            end else begin
                lo_offset_out <= manual_offset_code;
            end
        end
    end

    // ==============================================================
    // Transmit bit rate
    wire rate_tick;

    fcr_rate_gen #(
        .REF_DIV      (`FCR_REF_DIV)
    ) u_rate_gen (
        .mclk_in      (mclk_in),
        .sys_rst_in   (sys_rst_in),
        .enable_in    (tx_mode_in),
        .rate_code_in ({rate_hi_q, rate_lo_q}),
        .rate_scale_in(rate_cfg_q[`FCR_RATE_SCALE_BIT]),
        .bit_tick_out (rate_tick)
    );

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_bit_tick_out <= 1'b0;
        end else begin
            tx_bit_tick_out <= rate_tick;
        end
    end
endmodule // fcr_top
`default_nettype wire

// file: fcr_host.sv
// Host model: drives the byte-wide register strobes of the block.
// Assumes the block takes a strobe at the rising edge of mclk_in.
`timescale 1ns/1ps
`default_nettype none
`include "fcr_defs.vh"

module fcr_host (
    // Clock
    input  wire logic       mclk_in,
    // Register access
    output var  logic [6:0] reg_addr_out,
    output var  logic [7:0] reg_wdata_out,
    output var  logic       reg_we_out,
    output var  logic       reg_re_out,
    input  wire logic [7:0] reg_rdata_in
);
    // ==========================================================
    // Access tasks
    initial begin
        reg_addr_out = 7'h00;
        reg_wdata_out = 8'h00;
        reg_we_out = 1'b0;
        reg_re_out = 1'b0;
    end

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge mclk_in) #1;
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_we_out = 1'b1;
        @(posedge mclk_in) #1;
        reg_we_out = 1'b0;
        // Released data shows no stale value
        reg_wdata_out = ~d;
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge mclk_in) #1;
        reg_addr_out = a;
        reg_re_out = 1'b1;
        @(posedge mclk_in) #1;
        reg_re_out = 1'b0;
        reg_addr_out = ~a;
        @(posedge mclk_in);
        d = reg_rdata_in;
        #1;
    endtask

    task automatic set_rate(input logic [15:0] code, input logic slow);
        wr(`FCR_ADDR_RATE_HI, code[15:8]);
        wr(`FCR_ADDR_RATE_LO, code[7:0]);
        wr(`FCR_ADDR_RATE_CFG, {2'b00, slow, 5'h00});
        if (!slow && code > 16'h1999)
            wr(7'h58, 8'hc0);
    endtask
endmodule // fcr_host
`default_nettype wire

// file: fcr_top_properties.sv
// Checker for the correction and rate block, bound to its top module.
// Assumes no register write follows another within one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "fcr_defs.vh"

module fcr_top_properties (
    input wire logic       mclk_in,
    input wire logic       sys_rst_in,
    input wire logic [6:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_we_in,
    input wire logic       rx_mode_in,
    input wire logic       tx_mode_in,
    input wire logic       afc_enable_in,
    input wire logic [2:0] settle_wait_in,
    input wire logic       preamble_det_in,
    input wire logic       packet_end_in,
    input wire logic [8:0] deviation_code_out,
    input wire logic [9:0] lo_offset_out,
    input wire logic       high_band_out,
    input wire logic       afc_frozen_out,
    input wire logic       tx_bit_tick_out
);
    // ==========================================================
    // Properties
    logic [7:0] wd_q;
    wire        loop_on = rx_mode_in && afc_enable_in && !tx_mode_in;

    always_ff @(posedge mclk_in or posedge sys_rst_in)
        if (sys_rst_in) wd_q <= 8'h00;
        else if (reg_we_in) wd_q <= reg_wdata_in;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    a_dev_low: assert property (reg_we_in && reg_addr_in == `FCR_ADDR_DEV_LO
        |-> ##[1:2] deviation_code_out[7:0] == wd_q) else $error("deviation low wrong");
    a_dev_top: assert property (reg_we_in && reg_addr_in == `FCR_ADDR_MOD_CTRL2
        |-> ##[1:2] deviation_code_out[8] == wd_q[2]) else $error("deviation top wrong");
    a_manual_ofs: assert property (reg_we_in && reg_addr_in == `FCR_ADDR_OFS_LO
        && !(rx_mode_in && afc_enable_in) |-> ##[1:2] lo_offset_out[7:0] == wd_q)
        else $error("manual offset not applied");
    a_band_sel: assert property (reg_we_in && reg_addr_in == `FCR_ADDR_BAND
        |-> ##[1:2] high_band_out == wd_q[5]) else $error("band select wrong");
    a_frozen_hold: assert property (afc_frozen_out && $past(afc_frozen_out) && loop_on
        && $past(loop_on) && !$past(packet_end_in) && !packet_end_in
        |=> $stable(lo_offset_out)) else $error("frozen value moved");
    a_freeze_end: assert property (afc_frozen_out && packet_end_in && !preamble_det_in
        |-> ##[1:2] !afc_frozen_out) else $error("freeze not released");
    a_wait_zero: assert property ((loop_on && settle_wait_in == 3'h0) [*3]
        |-> lo_offset_out == 10'h000) else $error("correction with zero wait");
    a_tick_pulse: assert property (tx_bit_tick_out |=> !tx_bit_tick_out)
        else $error("bit tick longer than one cycle");
    a_no_tick_rx: assert property (!tx_mode_in [*4] |-> !tx_bit_tick_out)
        else $error("bit tick outside transmit");
endmodule // fcr_top_properties

bind fcr_top fcr_top_properties i_props (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_we_in(reg_we_in),
    .rx_mode_in(rx_mode_in), .tx_mode_in(tx_mode_in), .afc_enable_in(afc_enable_in),
    .settle_wait_in(settle_wait_in), .preamble_det_in(preamble_det_in),
    .packet_end_in(packet_end_in), .deviation_code_out(deviation_code_out),
    .lo_offset_out(lo_offset_out), .high_band_out(high_band_out),
    .afc_frozen_out(afc_frozen_out), .tx_bit_tick_out(tx_bit_tick_out));
`default_nettype wire

// file: fcr_top_test.sv
// Testbench for the correction and rate block with a host model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
`include "fcr_defs.vh"

module fcr_top_test;
    // ==========================================================
    // Signals and instances
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, d;
    logic we, re, rx, tx, afc_en, multi, rx_tick, pre, pend, hb, frz, txt;
    logic [2:0] gear, swait;
    logic signed [10:0] ferr;
    logic [8:0] dev;
    logic [9:0] lo;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;
    logic [6:0] ra [8] = '{7'h6e, 7'h6f, 7'h71, 7'h72, 7'h73, 7'h74, 7'h75, 7'h2a};
    logic [7:0] rv [8] = '{8'h0a, 8'h3d, 8'h00, 8'h20, 8'h00, 8'h00, 8'h35, 8'h00};

    fcr_host i_host (.mclk_in(mclk_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
        .reg_we_out(we), .reg_re_out(re), .reg_rdata_in(rdata));
    fcr_top i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_we_in(we), .reg_re_in(re), .reg_rdata_out(rdata),
        .rx_mode_in(rx), .tx_mode_in(tx), .afc_enable_in(afc_en), .afc_gear_in(gear),
        .settle_wait_in(swait), .multi_packet_in(multi), .rx_bit_tick_in(rx_tick),
        .freq_err_in(ferr), .preamble_det_in(pre), .packet_end_in(pend),
        .deviation_code_out(dev), .lo_offset_out(lo), .high_band_out(hb),
        .afc_frozen_out(frz), .tx_bit_tick_out(txt));

    initial begin
        forever #12.5 mclk_in = ~mclk_in;
    end

    // Cuts a hang short well past the longest rate gap
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic ticks(input int k, input logic signed [10:0] e);
        repeat (k) begin
            @(posedge mclk_in) #1;
            ferr = e;
            rx_tick = 1'b1;
            @(posedge mclk_in) #1;
            rx_tick = 1'b0;
            repeat (2) @(posedge mclk_in);
        end
        #1;
    endtask

    task automatic pulse_pre();
        @(posedge mclk_in) #1;
        pre = 1'b1;
        @(posedge mclk_in) #1;
        pre = 1'b0;
    endtask

    task automatic gap(output int k);
        k = 1;
        while (txt !== 1'b1) @(posedge mclk_in) #1;
        @(posedge mclk_in) #1;
        while (txt !== 1'b1) begin
            @(posedge mclk_in) #1;
            k++;
        end
    endtask

    task automatic end_sim();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // Sequence
    initial begin
        {rx, tx, afc_en, multi, rx_tick, pre, pend} = 7'h00;
        gear = 3'h0;
        swait = 3'h1;
        ferr = 11'h000;
        repeat (4) @(posedge mclk_in);
        #1 sys_rst_in = 1'b0;
        for (int i = 0; i < 8; i++) begin
            i_host.rd(ra[i], d);
            chk(d, rv[i]);
        end
        i_host.rd(7'h00, d);
        chk(d, 8'h00);
        chk(hb, 1'b1);
        $display("defaults done");
        i_host.wr(`FCR_ADDR_DEV_LO, 8'h55);
        i_host.wr(`FCR_ADDR_MOD_CTRL2, 8'h04);
        i_host.wr(`FCR_ADDR_BAND, 8'h15);
        @(posedge mclk_in) #1;
        chk(dev, 9'h155);
        chk(hb, 1'b0);
        rx = 1'b1;
        i_host.wr(`FCR_ADDR_OFS_LO, 8'h60);
        i_host.wr(`FCR_ADDR_OFS_HI, 8'hff);
        i_host.rd(`FCR_ADDR_OFS_HI, d);
        chk(d, 8'h03);
        chk(lo, 10'h360);
        $display("manual done");
        afc_en = 1'b1;
        i_host.wr(`FCR_ADDR_LIMIT, 8'h02);
        ticks(12, 11'sd3);
        i_host.rd(`FCR_ADDR_CORR, d);
        chk(d, 8'h08);
        chk(lo, 10'h008);
        ticks(16, -11'sd5);
        i_host.wr(`FCR_ADDR_CORR, 8'h55);
        i_host.rd(`FCR_ADDR_CORR, d);
        chk(d, 8'hf8);
        chk(lo, 10'h3f8);
        multi = 1'b1;
        pulse_pre();
        ticks(8, 11'sd3);
        chk(lo, 10'h3f8);
        chk(frz, 1'b1);
        pend = 1'b1;
        @(posedge mclk_in) #1;
        pend = 1'b0;
        i_host.rd(`FCR_ADDR_CORR, d);
        chk(d, 8'h00);
        chk(frz, 1'b0);
        i_host.wr(`FCR_ADDR_LIMIT, 8'h40);
        gear = 3'h2;
        ticks(2, 11'sd8);
        i_host.rd(`FCR_ADDR_CORR, d);
        chk(d, 8'h02);
        swait = 3'h0;
        repeat (4) @(posedge mclk_in);
        #1 chk(lo, 10'h000);
        $display("loop done");
        tx = 1'b1;
        repeat (2) @(posedge mclk_in) #1;
        chk(lo, 10'h360);
        tx = 1'b0;
        afc_en = 1'b0;
        rx = 1'b0;
        i_host.set_rate(16'h8000, 1'b0);
        chk(lo, 10'h360);
        tx = 1'b1;
        gap(n);
        chk(n, 80);
        tx = 1'b0;
        i_host.set_rate(16'h8000, 1'b1);
        tx = 1'b1;
        gap(n);
        chk(n, 2560);
        @(posedge mclk_in) #1;
        tx = 1'b0;
        rx = 1'b1;
        repeat (100) @(posedge mclk_in);
        $display("rate done");
        end_sim();
    end
endmodule // fcr_top_test
`default_nettype wire
